// *** rtl/dla_pkg.sv ***
// package: shared types and constants for the data load address unit
package dla_pkg;
    localparam int DLA_DW = 32;
    localparam logic [31:0] DLA_WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] DLA_HALF_STEP = 32'h0000_0002;
    localparam logic [1:0] DLA_WORD_ALIGN_MASK = 2'h3;
    localparam logic [1:0] DLA_HALF_ALIGN_MASK = 2'h1;
    localparam int DLA_SHORT_WORD_W = 6;
    localparam int DLA_LONG_WORD_W = 18;
    localparam int DLA_FRAME_WORD_W = 7;
    localparam int DLA_SHORT_HALF_W = 5;
    localparam int DLA_LONG_HALF_W = 17;
    localparam logic [2:0] DLA_FRAME_PTR_IDX = 3'h7;
    localparam logic [2:0] DLA_STACK_PTR_IDX = 3'h6;
    localparam logic [31:0] DLA_PTR_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        DLA_AM_PLAIN,
        DLA_AM_POST_INC,
        DLA_AM_POST_DEC,
        DLA_AM_SHORT_OFS,
        DLA_AM_LONG_ADD,
        DLA_AM_LONG_SUB,
        DLA_AM_FRAME_NEG,
        DLA_AM_INDEX_INC
    } dla_mode_t;

    typedef enum logic [1:0] {
        DLA_SZ_WORD,
        DLA_SZ_HALF_ZERO,
        DLA_SZ_HALF_SIGN
    } dla_size_t;

    typedef enum logic [1:0] {
        DLA_SRC_PTR,
        DLA_SRC_INDEX
    } dla_src_t;

    typedef struct packed {
        dla_size_t size;
        dla_mode_t mode;
        dla_src_t src;
        logic [2:0] dest;
        logic [2:0] base;
        logic [2:0] step;
        logic [17:0] offset;
        logic sign_hint;
    } dla_op_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] new_base;
        logic base_wr;
        logic misaligned;
    } dla_agen_t;
endpackage

// *** rtl/dla_agen.sv ***
// address generation and alignment check for one load
`timescale 1ns/1ps
module dla_agen (
    input wire dla_pkg::dla_op_t op_in,
    input wire logic [31:0] base_val_in,
    input wire logic [31:0] step_val_in,
    output dla_pkg::dla_agen_t res_out
);
    function automatic logic [31:0] zext_ofs(input logic [17:0] v);
        zext_ofs = {14'h0, v};
    endfunction

    logic [31:0] step_sz;
    logic [31:0] ofs;
    logic word_sz;

    always_comb begin
        word_sz = (op_in.size == dla_pkg::DLA_SZ_WORD);
        step_sz = dla_pkg::DLA_HALF_STEP;
        if (word_sz) begin
            step_sz = dla_pkg::DLA_WORD_STEP;
        end
        ofs = zext_ofs(op_in.offset);
        res_out.addr = base_val_in;
        res_out.new_base = base_val_in;
        res_out.base_wr = 1'b0;
        // access address uses pre-modify base
        case (op_in.mode)
            dla_pkg::DLA_AM_PLAIN: begin
            end
            dla_pkg::DLA_AM_POST_INC: begin
                res_out.new_base = base_val_in + step_sz;
                res_out.base_wr = 1'b1;
            end
            dla_pkg::DLA_AM_POST_DEC: begin
                res_out.new_base = base_val_in - step_sz;
                res_out.base_wr = 1'b1;
            end
            dla_pkg::DLA_AM_SHORT_OFS: begin
                res_out.addr = base_val_in + ofs;
            end
            dla_pkg::DLA_AM_LONG_ADD: begin
                res_out.addr = base_val_in + ofs;
            end
            dla_pkg::DLA_AM_LONG_SUB: begin
                res_out.addr = base_val_in - ofs;
            end
            dla_pkg::DLA_AM_FRAME_NEG: begin
                res_out.addr = base_val_in - ofs;
            end
            dla_pkg::DLA_AM_INDEX_INC: begin
                res_out.new_base = base_val_in + step_val_in;
                res_out.base_wr = (op_in.base != op_in.step);
            end
            default: begin
            end
        endcase
        res_out.misaligned = word_sz
            ? |(res_out.addr[1:0] & dla_pkg::DLA_WORD_ALIGN_MASK)
            : |(res_out.addr[1:0] & dla_pkg::DLA_HALF_ALIGN_MASK);
    end
endmodule

// *** rtl/dla_extend.sv ***
// result shaping: word pass-through or half-word extension
`timescale 1ns/1ps
module dla_extend (
    input wire dla_pkg::dla_size_t size_in,
    input wire logic [1:0] addr_lo_in,
    input wire logic [31:0] mem_data_in,
    output logic [31:0] data_out
);
    logic [15:0] half;

    always_comb begin
        // little-endian lane pick on the 32-bit bus
        half = addr_lo_in[1] ? mem_data_in[31:16] : mem_data_in[15:0];
        case (size_in)
            dla_pkg::DLA_SZ_WORD: data_out = mem_data_in;
            dla_pkg::DLA_SZ_HALF_ZERO: data_out = {16'h0000, half};
            dla_pkg::DLA_SZ_HALF_SIGN: begin
                data_out = {{16{half[15]}}, half};
            end
            default: data_out = mem_data_in;
        endcase
    end
endmodule

// *** rtl/dla_unit.sv ***
// data load address unit: decode, address registers, memory access
`timescale 1ns/1ps
module dla_unit (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic issue_valid_in,
    input wire dla_pkg::dla_op_t issue_op_in,
    input wire logic issue_wide_in,
    input wire logic issue_paired_in,
    input wire logic ptr_wr_in,
    input wire logic [2:0] ptr_wr_sel_in,
    input wire logic [31:0] ptr_wr_data_in,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_ack_in,
    output logic issue_ready_out,
    output logic issue_reject_out,
    output logic mem_req_out,
    output logic [31:0] mem_addr_out,
    output logic dreg_we_out,
    output logic [2:0] dreg_sel_out,
    output logic [31:0] dreg_data_out,
    output logic misalign_exc_out,
    output logic [255:0] ptr_file_out
);
    typedef enum logic [1:0] {
        DLA_ST_IDLE,
        DLA_ST_WAIT,
        DLA_ST_DONE
    } dla_state_t;

    function automatic logic is_long(input dla_pkg::dla_mode_t m);
        is_long = (m == dla_pkg::DLA_AM_LONG_ADD) ||
                  (m == dla_pkg::DLA_AM_LONG_SUB);
    endfunction

    function automatic logic is_word(input dla_pkg::dla_size_t s);
        is_word = (s == dla_pkg::DLA_SZ_WORD);
    endfunction

    dla_state_t state_q;
    logic [31:0] ptr_q [8];
    dla_pkg::dla_op_t op_q;
    dla_pkg::dla_agen_t agen_q;
    dla_pkg::dla_op_t op_n;
    dla_pkg::dla_agen_t agen;
    logic [31:0] ext_data;
    logic enc_bad;
    logic take;
    logic issue_ready_q;
    logic issue_reject_q;
    logic mem_req_q;
    logic [31:0] mem_addr_q;
    logic dreg_we_q;
    logic [2:0] dreg_sel_q;
    logic [31:0] dreg_data_q;
    logic misalign_q;

    // offsets arrive in byte units; clip to the field widths except long forms, kept to 17 (word) or 16 (half) bits
    always_comb begin
        op_n = issue_op_in;
        op_n.sign_hint = 1'b0;
        // forms without an offset see zero, never stale field bits
        op_n.offset = '0;
        case (issue_op_in.mode)
            dla_pkg::DLA_AM_SHORT_OFS: begin
                if (is_word(issue_op_in.size)) begin
                    op_n.offset[5:2] = issue_op_in.offset[5:2];
                end else begin
                    op_n.offset[4:1] = issue_op_in.offset[4:1];
                end
            end
            dla_pkg::DLA_AM_FRAME_NEG: begin
                op_n.base = dla_pkg::DLA_FRAME_PTR_IDX;
                op_n.offset[6:2] = issue_op_in.offset[6:2];
            end
            dla_pkg::DLA_AM_LONG_ADD, dla_pkg::DLA_AM_LONG_SUB: begin
                if (is_word(issue_op_in.size)) begin
                    op_n.offset[16:2] = issue_op_in.offset[16:2];
                end else begin
                    op_n.offset[15:1] = issue_op_in.offset[15:1];
                end
            end
            default: begin
            end
        endcase
    end

    // long forms must be flagged wide and never paired
    always_comb begin
        enc_bad = 1'b0;
        if (is_long(issue_op_in.mode) != issue_wide_in) begin
            enc_bad = 1'b1;
        end
        if (issue_wide_in && issue_paired_in) begin
            enc_bad = 1'b1;
        end
        // half loads address only through pointer registers
        if (!is_word(issue_op_in.size) &&
            issue_op_in.src != dla_pkg::DLA_SRC_PTR) begin
            enc_bad = 1'b1;
        end
        // frame form exists for whole words only
        if (!is_word(issue_op_in.size) &&
            issue_op_in.mode == dla_pkg::DLA_AM_FRAME_NEG) begin
            enc_bad = 1'b1;
        end
    end

    assign take = issue_valid_in && state_q == DLA_ST_IDLE;

    dla_agen u_agen (
        .op_in(op_n),
        .base_val_in(ptr_q[op_n.base]),
        .step_val_in(ptr_q[op_n.step]),
        .res_out(agen)
    );

    dla_extend u_ext (
        .size_in(op_q.size),
        .addr_lo_in(agen_q.addr[1:0]),
        .mem_data_in(mem_rdata_in),
        .data_out(ext_data)
    );

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_q <= DLA_ST_IDLE;
        end else begin
            case (state_q)
                DLA_ST_IDLE: begin
                    if (take && !enc_bad && !agen.misaligned) begin
                        state_q <= DLA_ST_WAIT;
                    end
                end
                DLA_ST_WAIT: begin
                    if (mem_ack_in) begin
                        state_q <= DLA_ST_DONE;
                    end
                end
                DLA_ST_DONE: state_q <= DLA_ST_IDLE;
                default: state_q <= DLA_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            op_q <= '0;
            agen_q <= '0;
        end else if (take) begin
            op_q <= op_n;
            agen_q <= agen;
        end
    end

    // pointer file; flags are not held here at all
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 8; i++) begin
                ptr_q[i] <= dla_pkg::DLA_PTR_RESET;
            end
        end else begin
            if (ptr_wr_in && state_q == DLA_ST_IDLE) begin
                ptr_q[ptr_wr_sel_in] <= ptr_wr_data_in;
            end
            // update after access completes; faulted loads never get here
            if (state_q == DLA_ST_WAIT && mem_ack_in && agen_q.base_wr) begin
                ptr_q[op_q.base] <= agen_q.new_base;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            mem_req_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
        end else if (take && !enc_bad && !agen.misaligned) begin
            mem_req_q <= 1'b1;
            mem_addr_q <= {agen.addr[31:2], 2'h0};
        end else if (state_q == DLA_ST_WAIT && mem_ack_in) begin
            mem_req_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            dreg_we_q <= 1'b0;
            dreg_sel_q <= 3'h0;
            dreg_data_q <= 32'h0000_0000;
        end else begin
            dreg_we_q <= state_q == DLA_ST_WAIT && mem_ack_in;
            if (state_q == DLA_ST_WAIT && mem_ack_in) begin
                dreg_sel_q <= op_q.dest;
                dreg_data_q <= ext_data;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            misalign_q <= 1'b0;
            issue_reject_q <= 1'b0;
            issue_ready_q <= 1'b0;
        end else begin
            misalign_q <= take && !enc_bad && agen.misaligned;
            issue_reject_q <= take && enc_bad;
            // ready while idle and not taking a new op, and again in the cycle after DONE
            issue_ready_q <= (state_q == DLA_ST_IDLE && !take) ||
                             state_q == DLA_ST_DONE;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ptr_file_out[i*32 +: 32] = ptr_q[i];
        end
    end

    assign issue_ready_out = issue_ready_q;
    assign issue_reject_out = issue_reject_q;
    assign mem_req_out = mem_req_q;
    assign mem_addr_out = mem_addr_q;
    assign dreg_we_out = dreg_we_q;
    assign dreg_sel_out = dreg_sel_q;
    assign dreg_data_out = dreg_data_q;
    assign misalign_exc_out = misalign_q;
endmodule

// *** verif/dla_unit_asserts.sv ***
// checker: port assertions for the load unit
`timescale 1ns/1ps
module dla_unit_asserts (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic ptr_wr_in,
    input wire logic mem_ack_in,
    input wire logic issue_reject_out,
    input wire logic mem_req_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic dreg_we_out,
    input wire logic misalign_exc_out,
    input wire logic [255:0] ptr_file_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);
    req_hold_a: assert property (
        mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
        else $error("request moved before ack");
    addr_align_a: assert property (
        mem_req_out |-> mem_addr_out[1:0] == 2'h0)
        else $error("bus address not word aligned");
    ack_write_a: assert property (
        mem_req_out && mem_ack_in |=> dreg_we_out && !mem_req_out)
        else $error("no register write after ack");
    write_cause_a: assert property (
        dreg_we_out |-> $past(mem_ack_in) && $past(mem_req_out))
        else $error("register write without bus answer");
    write_pulse_a: assert property (
        dreg_we_out |=> !dreg_we_out && !mem_req_out)
        else $error("write not a single pulse");
    fault_quiet_a: assert property (
        misalign_exc_out |-> !mem_req_out && !dreg_we_out
            && $stable(ptr_file_out) ##1 !dreg_we_out)
        else $error("fault with access or update");
    reject_quiet_a: assert property (
        issue_reject_out |-> !mem_req_out && !misalign_exc_out
            && !dreg_we_out)
        else $error("reject with activity");
    ptr_cause_a: assert property (
        !$stable(ptr_file_out) |-> dreg_we_out || $past(ptr_wr_in))
        else $error("pointer changed without cause");
    load_done_c: cover property (dreg_we_out);
    fault_c: cover property (misalign_exc_out);
    reject_c: cover property (issue_reject_out);
    ptr_upd_c: cover property (dreg_we_out && !$stable(ptr_file_out));
endmodule
bind dla_unit dla_unit_asserts chk_u (.*);

// *** verif/dla_mem_model.sv ***
// far-side data memory with selectable answer delay
`timescale 1ns/1ps
module dla_mem_model (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic mem_req_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [3:0] wait_in,
    output logic [31:0] mem_rdata_out,
    output logic mem_ack_out
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk_sys_in) begin
        mem_ack_out <= 1'b0;
        // data valid only with ack; flip it otherwise so stale reads show
        mem_rdata_out <= ~mem_rdata_out;
        if (sys_rst_in) begin
            cnt_q <= 4'h0;
            mem_rdata_out <= 32'h0;
        end else if (mem_req_in && !mem_ack_out) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == wait_in) begin
                cnt_q <= 4'h0;
                mem_ack_out <= 1'b1;
                mem_rdata_out <= {mem_addr_in[15:0] ^ 16'h5A3C,
                    ~mem_addr_in[15:0]};
            end
        end
    end
endmodule

// *** verif/dla_unit_tb_top.sv ***
// testbench: corner and random loads for the load unit
`timescale 1ns/1ps
module dla_unit_tb_top;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic issue_valid_in = 1'b0;
    dla_pkg::dla_op_t issue_op_in = '0;
    logic issue_wide_in = 1'b0;
    logic issue_paired_in = 1'b0;
    logic ptr_wr_in = 1'b0;
    logic [2:0] ptr_wr_sel_in = 3'h0;
    logic [31:0] ptr_wr_data_in = 32'h0;
    logic [3:0] mem_wait = 4'h0;
    logic [31:0] mem_rdata_in, mem_addr_out, dreg_data_out;
    logic mem_ack_in, issue_ready_out, issue_reject_out, mem_req_out;
    logic dreg_we_out, misalign_exc_out;
    logic [2:0] dreg_sel_out;
    logic [255:0] ptr_file_out;
    logic [31:0] ptr [8];
    int n_fail = 0;
    int num_checks = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    dla_unit dut_u (.*);
    dla_mem_model mem_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out),
        .wait_in(mem_wait), .mem_rdata_out(mem_rdata_in),
        .mem_ack_out(mem_ack_in));
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic set_ptr(input logic [2:0] i, input logic [31:0] v);
        @(negedge clk_sys_in);
        ptr_wr_in = 1'b1;
        ptr_wr_sel_in = i;
        ptr_wr_data_in = v;
        @(negedge clk_sys_in);
        ptr_wr_in = 1'b0;
        ptr[i] = v;
    endtask
    // reset image: all outputs quiet, pointers back to reset value
    task automatic rst_check();
        logic [31:0] z;
        z = {24'h0, issue_ready_out, issue_reject_out, mem_req_out,
            dreg_we_out, misalign_exc_out, dreg_sel_out};
        chk(z, 32'h0);
        chk(mem_addr_out, 32'h0);
        chk(dreg_data_out, 32'h0);
        for (int i = 0; i < 8; i++) begin
            ptr[i] = dla_pkg::DLA_PTR_RESET;
            chk(ptr_file_out[i*32 +: 32], ptr[i]);
        end
    endtask
    function automatic dla_pkg::dla_op_t mk(int sz, int md, logic [31:0] r);
        dla_pkg::dla_op_t o;
        int w;
        o = '0;
        o.size = dla_pkg::dla_size_t'(sz);
        o.mode = dla_pkg::dla_mode_t'(md);
        {o.dest, o.base, o.step, o.sign_hint} = r[31:22];
        if (md == 6) o.base = 3'h7;
        w = md == 3 ? 6 : (md == 4 || md == 5) ? 17 : md == 6 ? 7 : 0;
        if (sz != 0 && w != 0) w--;
        o.offset = 18'(r & ((32'h1 << w) - 32'h1) &
            (sz != 0 ? ~32'h1 : ~32'h3));
        return o;
    endfunction
    task automatic load(input dla_pkg::dla_op_t o, input logic w,
        input logic p);
        logic [31:0] b, a, m, e, sa, g, x;
        logic hf, lg, rej, mis;
        int k;
        b = ptr[o.base];
        hf = o.size != dla_pkg::DLA_SZ_WORD;
        lg = o.mode inside {dla_pkg::DLA_AM_LONG_ADD,
            dla_pkg::DLA_AM_LONG_SUB};
        case (o.mode)
            dla_pkg::DLA_AM_SHORT_OFS,
            dla_pkg::DLA_AM_LONG_ADD: a = b + o.offset;
            dla_pkg::DLA_AM_LONG_SUB,
            dla_pkg::DLA_AM_FRAME_NEG: a = b - o.offset;
            default: a = b;
        endcase
        rej = w != lg || (w && p) || (hf &&
            (o.mode == dla_pkg::DLA_AM_FRAME_NEG ||
            o.src == dla_pkg::DLA_SRC_INDEX));
        mis = !rej && (hf ? a[0] : a[1:0] != 2'h0);
        m = {a[15:2] ^ 14'h168F, 2'h0, ~a[15:2], 2'h3};
        e = a[1] ? {16'h0, m[31:16]} : {16'h0, m[15:0]};
        if (!hf) e = m;
        else if (o.size == dla_pkg::DLA_SZ_HALF_SIGN) e[31:16] = {16{e[15]}};
        sa = ~a;
        @(negedge clk_sys_in);
        chk({31'h0, issue_ready_out}, 32'h1);
        issue_valid_in = 1'b1;
        issue_op_in = o;
        issue_wide_in = w;
        issue_paired_in = p;
        mem_wait = $urandom_range(3) == 0 ? 4'h9 : 4'($urandom_range(2));
        @(negedge clk_sys_in);
        issue_valid_in = 1'b0;
        chk({31'h0, issue_ready_out}, 32'h0);
        k = 0;
        while (k < 40 && {dreg_we_out, issue_reject_out, misalign_exc_out}
            === 3'h0) begin
            if (mem_req_out === 1'b1) sa = mem_addr_out;
            @(negedge clk_sys_in);
            k++;
        end
        g = {29'h0, issue_reject_out, misalign_exc_out, dreg_we_out};
        x = {29'h0, rej, mis, !(rej || mis)};
        chk(g, x);
        if (!(rej || mis)) begin
            chk(sa, {a[31:2], 2'h0});
            chk(dreg_data_out, e);
            chk({29'h0, dreg_sel_out}, {29'h0, o.dest});
            case (o.mode)
                dla_pkg::DLA_AM_POST_INC: ptr[o.base] = b + (hf ? 2 : 4);
                dla_pkg::DLA_AM_POST_DEC: ptr[o.base] = b - (hf ? 2 : 4);
                dla_pkg::DLA_AM_INDEX_INC:
                    if (o.base != o.step) ptr[o.base] = b + ptr[o.step];
                default: ;
            endcase
        end
        for (int i = 0; i < 8; i++)
            chk(ptr_file_out[i*32 +: 32], ptr[i]);
        @(negedge clk_sys_in);
    endtask
    initial begin
        dla_pkg::dla_op_t o;
        logic [31:0] r, v;
        int md;
        logic w;
        void'($urandom(32'h9601ADD7));
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        rst_check();
        for (int i = 0; i < 8; i++)
            set_ptr(3'(i), 32'h8000 + 32'(i) * 32'h40);
        // field maxima, base equals step, aligned and skewed frame base
        for (int j = 0; j < 3; j++)
            for (int s = 0; s < 3; s++)
                for (md = 0; md < 8; md++) begin
                    set_ptr(3'h7, 32'h8000 + 32'(j));
                    load(mk(s, md, 32'hFFFFFFFF), md == 4 || md == 5, 1'b0);
                end
        // second reset between loads: pointers must fall back
        sys_rst_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        rst_check();
        for (int n = 0; n < 400; n++) begin
            r = $urandom;
            v = $urandom;
            if (!r[7]) v[1:0] = 2'h0;
            if (r[1:0] == 2'h0) set_ptr(r[6:4], v);
            md = $urandom_range(7);
            o = mk($urandom_range(2), md, $urandom);
            if (o.size != dla_pkg::DLA_SZ_WORD && r[12:9] == 4'h0)
                o.src = dla_pkg::DLA_SRC_INDEX;
            w = (md == 4 || md == 5) ^ (r[16:13] == 4'h0);
            load(o, w, r[17] && (!w || r[20:18] == 3'h0));
        end
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        n_fail++;
        complete_run();
    end
endmodule
